// ==== hdl/eep_cfg.svh ====
// Purpose: Constants of the two-wire memory slave front end
// Assumes: System clock of 250 MHz
// Notes:   Included by the package and the slave module
`ifndef EEP_CFG_SVH
`define EEP_CFG_SVH

// ****************************************
// Select byte layout
// ****************************************
`define EEP_SEL_TYPE_MSB   7
`define EEP_SEL_TYPE_LSB   4
`define EEP_SEL_CS_MSB     3
`define EEP_SEL_CS_LSB     1
`define EEP_SEL_RW_BIT     0
`define EEP_TYPE_MEMORY    4'h5 // Arbitrary type code

// ****************************************
// Array and page geometry
// ****************************************
`define EEP_ADDR_W         11
`define EEP_PAGE_W         4
`define EEP_PAGE_BYTES     16
`define EEP_BITS_PER_BYTE  4'h8

// ****************************************
// Timing
// ****************************************
`define EEP_CLK_NS         4
`define EEP_WRITE_CYCLE_NS 5000
`define EEP_WRITE_CYCLE_CYC \
  ((`EEP_WRITE_CYCLE_NS + `EEP_CLK_NS - 1) / `EEP_CLK_NS)
`define EEP_TIMER_W        16

`endif

// ==== hdl/eep_pkg.sv ====
// Purpose: Types of the two-wire memory slave front end
// Assumes: Constants come from eep_cfg.svh
// Notes:   Types only
`include "eep_cfg.svh"

package eep_pkg;

  // ****************************************
  // Protocol states
  // ****************************************
  typedef enum logic [3:0] {
    EEP_IDLE     = 4'h0,
    EEP_SEL      = 4'h1,
    EEP_SEL_ACK  = 4'h2,
    EEP_ADDR     = 4'h3,
    EEP_ADDR_ACK = 4'h4,
    EEP_WDATA    = 4'h5,
    EEP_WACK     = 4'h6,
    EEP_RDATA    = 4'h7,
    EEP_RACK     = 4'h8,
    EEP_BUSY     = 4'h9
  } eep_state_type;

  // ****************************************
  // Array write port
  // ****************************************
  typedef struct packed {
    logic                    en;
    logic [`EEP_ADDR_W-1:0]  addr;
    logic [7:0]              data;
  } eep_wr_type;

endpackage

// ==== hdl/eep_slave.sv ====
// Purpose: Two-wire serial slave front end of a byte memory array
// Assumes: Bus lines sampled by clk_sys, array outside this block
// Notes:   Page latch commits to the array during the write cycle
//
// Contract
// - Start is data falling while clock high
// - Ignore bus activity until a start
// - Stop is data rising while clock high
// - Receiver pulls data low in 9th pulse
// - Sample data on rising clock edges
// - Select byte MSB first, type then chip-select
// - Respond only when chip-select matches pins
// - Select bit 0 is direction, 1 read
// - Ack matching select, else release and standby
// - Large densities take upper address from select
// - After write select, ack the word address
// - Write cycle only on stop after data ack
// - Ignore bus during internal write cycle
// - Write protect seen: no data ack, no write
// - Page write of 1 to 16 bytes
// - Only low 4 address bits increment on write
// - Busy: no select ack; afterwards ack again
// - Reads ignore write protect
// - Random read: dummy write, restart, read select
// - Current read outputs counter byte then increments
// - Acked read continues; counter wraps to zero
// - Master no-ack after read byte: standby
// - Chip-select compared on b3, b2, b1; code skips the bits that upper_bits_used takes as address
`timescale 1ns/100ps
`include "eep_cfg.svh"

module eep_slave
  import eep_pkg::*;
#(
  parameter int WRITE_CYCLE_CYC = `EEP_WRITE_CYCLE_CYC
) (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   srst,
  // Serial bus, data is open drain
  input  wire logic                   scl_in,
  input  wire logic                   sda_in,
  output wire logic                   sda_out,
  output wire logic                   sda_oe,
  // Strap pins
  input  wire logic                   chip_select_pin_0,
  input  wire logic                   chip_select_pin_1,
  input  wire logic                   chip_select_pin_2,
  input  wire logic                   write_protect_input,
  input  wire logic [1:0]             upper_bits_used,
  // Array ports
  output wire logic [`EEP_ADDR_W-1:0] mem_rd_addr,
  input  wire logic [7:0]             mem_rd_data,
  output eep_wr_type                  mem_wr,
  // Status
  output wire logic                   write_busy
);

  // ****************************************
  // Pin synchronisers and edge detection
  // ****************************************
  logic [2:0] scl_pipe;
  logic [2:0] sda_pipe;
  logic [1:0] wp_pipe;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic       sda_s;
  logic       wp_s;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      scl_pipe <= 3'h7;
      sda_pipe <= 3'h7;
      wp_pipe  <= 2'h0;
    end else begin
      scl_pipe <= {scl_pipe[1:0], scl_in};
      sda_pipe <= {sda_pipe[1:0], sda_in};
      wp_pipe  <= {wp_pipe[0], write_protect_input};
    end
  end

  assign sda_s    = sda_pipe[1];
  assign wp_s     = wp_pipe[1];
  assign scl_rise = scl_pipe[1] & ~scl_pipe[2];
  assign scl_fall = ~scl_pipe[1] & scl_pipe[2];
  // Clock held high across both samples of the data edge
  assign start_det = scl_pipe[1] & scl_pipe[2]
                   & ~sda_pipe[1] & sda_pipe[2];
  assign stop_det  = scl_pipe[1] & scl_pipe[2]
                   & sda_pipe[1] & ~sda_pipe[2];

  // ****************************************
  // Select decode
  // ****************************************
  logic [2:0]             addr_hi_mask;
  logic [2:0]             cs_pins;
  logic                   sel_match;
  logic                   launch_ok;
  logic [`EEP_ADDR_W-1:0] addr_mask;
  logic [7:0]             shreg;
  logic [3:0]             bitcnt;
  logic                   have_data;
  logic                   wp_seen;
  eep_state_type          state;
  logic [`EEP_ADDR_W-1:0] addr;

  assign cs_pins = {chip_select_pin_2, chip_select_pin_1,
                    chip_select_pin_0};
  assign addr_hi_mask = {upper_bits_used == 2'h3,
                         upper_bits_used >= 2'h2,
                         upper_bits_used != 2'h0};
  assign addr_mask = {addr_hi_mask, 8'hff};
  assign sel_match =
    (shreg[`EEP_SEL_TYPE_MSB:`EEP_SEL_TYPE_LSB] == `EEP_TYPE_MEMORY)
    && (((shreg[`EEP_SEL_CS_MSB:`EEP_SEL_CS_LSB] ^ cs_pins)
         & ~addr_hi_mask) == 3'h0);
  // Stop in the slot right after a data acknowledge
  assign launch_ok = (state == EEP_WDATA) && (bitcnt <= 4'h1)
                     && have_data;

  // ****************************************
  // Page latch
  // ****************************************
  logic [7:0]                 page_data [`EEP_PAGE_BYTES];
  logic [`EEP_PAGE_BYTES-1:0] page_valid;
  logic                       latch_en;
  logic                       page_clr;

  genvar gi;
  generate
    for (gi = 0; gi < `EEP_PAGE_BYTES; gi++) begin : g_page
      logic       next_valid;
      logic [7:0] next_data;
      logic       hit;
      always_comb begin
        hit        = latch_en && (addr[`EEP_PAGE_W-1:0] == gi);
        next_valid = page_clr ? 1'b0 : (page_valid[gi] | hit);
        next_data  = hit ? shreg : page_data[gi];
      end
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          page_valid[gi] <= 1'b0;
          page_data[gi]  <= 8'h00;
        end else begin
          page_valid[gi] <= next_valid;
          page_data[gi]  <= next_data;
        end
      end
    end
  endgenerate

  // ****************************************
  // Protocol engine
  // ****************************************
  eep_state_type            next_state;
  logic [7:0]               next_shreg;
  logic [3:0]               next_bitcnt;
  logic [`EEP_ADDR_W-1:0]   next_addr;
  logic                     next_oe;
  logic                     next_have_data;
  logic                     next_wp_seen;
  logic [`EEP_TIMER_W-1:0]  next_timer;
  logic [`EEP_TIMER_W-1:0]  timer;
  logic                     oe;
  logic                     rd_load;
  eep_wr_type               next_wr;
  logic [`EEP_PAGE_W-1:0]   commit_idx;

  assign commit_idx = timer[`EEP_PAGE_W-1:0];

  always_comb begin
    next_state     = state;
    next_shreg     = shreg;
    next_bitcnt    = bitcnt;
    next_addr      = addr;
    next_oe        = oe;
    next_have_data = have_data;
    next_wp_seen   = wp_seen;
    next_timer     = timer;
    latch_en       = 1'b0;
    page_clr       = 1'b0;
    rd_load        = 1'b0;
    next_wr        = '0;
    if (state == EEP_BUSY) begin
      // Bus is not looked at here at all
      next_oe    = 1'b0;
      next_timer = timer + 16'h0001;
      next_wr.en = (timer < 16'(`EEP_PAGE_BYTES))
                   && page_valid[commit_idx];
      next_wr.addr = {addr[`EEP_ADDR_W-1:`EEP_PAGE_W], commit_idx};
      next_wr.data = page_data[commit_idx];
      if (timer >= 16'(WRITE_CYCLE_CYC - 1)) begin
        next_state = EEP_IDLE;
        page_clr   = 1'b1;
      end
    end else if (start_det) begin
      next_state     = EEP_SEL;
      next_bitcnt    = 4'h0;
      next_oe        = 1'b0;
      next_have_data = 1'b0;
      next_wp_seen   = wp_s;
      page_clr       = 1'b1;
    end else if (stop_det) begin
      next_oe = 1'b0;
      if (launch_ok) begin
        next_state = EEP_BUSY;
        next_timer = '0;
      end else begin
        next_state = EEP_IDLE;
        page_clr   = 1'b1;
      end
    end else begin
      if (state inside {EEP_SEL, EEP_SEL_ACK, EEP_ADDR})
        next_wp_seen = wp_seen | wp_s;
      case (state)
        EEP_SEL, EEP_ADDR, EEP_WDATA: begin
          if (scl_rise && bitcnt < `EEP_BITS_PER_BYTE) begin
            next_shreg  = {shreg[6:0], sda_s};
            next_bitcnt = bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == `EEP_BITS_PER_BYTE) begin
            next_bitcnt = 4'h0;
            if (state == EEP_SEL) begin
              if (sel_match) begin
                next_state = EEP_SEL_ACK;
                next_oe    = 1'b1;
                next_addr  = {(shreg[`EEP_SEL_CS_MSB:`EEP_SEL_CS_LSB]
                               & addr_hi_mask), addr[7:0]};
              end else begin
                next_state = EEP_IDLE;
              end
            end else if (state == EEP_ADDR) begin
              next_state = EEP_ADDR_ACK;
              next_oe    = 1'b1;
              next_addr  = {addr[`EEP_ADDR_W-1:8], shreg} & addr_mask;
            end else begin
              next_state = EEP_WACK;
              next_oe    = ~wp_seen;
              if (!wp_seen) begin
                latch_en       = 1'b1;
                next_have_data = 1'b1;
                next_addr      = {addr[`EEP_ADDR_W-1:`EEP_PAGE_W],
                                  addr[`EEP_PAGE_W-1:0] + 4'h1};
              end
            end
          end
        end
        EEP_SEL_ACK: begin
          if (scl_fall) begin
            next_oe = 1'b0;
            if (shreg[`EEP_SEL_RW_BIT]) begin
              rd_load = 1'b1;
            end else begin
              next_state = EEP_ADDR;
            end
          end
        end
        EEP_ADDR_ACK, EEP_WACK: begin
          if (scl_fall) begin
            next_oe    = 1'b0;
            next_state = EEP_WDATA;
          end
        end
        EEP_RDATA: begin
          if (scl_fall) begin
            if (bitcnt == 4'h7) begin
              next_oe    = 1'b0;
              next_state = EEP_RACK;
            end else begin
              next_shreg  = {shreg[6:0], 1'b0};
              next_oe     = ~shreg[6];
              next_bitcnt = bitcnt + 4'h1;
            end
          end
        end
        EEP_RACK: begin
          if (scl_rise && sda_s) begin
            next_state = EEP_IDLE;
          end else if (scl_fall) begin
            rd_load = 1'b1;
          end
        end
        default: begin
          next_oe = 1'b0;
        end
      endcase
    end
    if (rd_load) begin
      // Array read data is taken in the same cycle as the address
      next_state  = EEP_RDATA;
      next_shreg  = mem_rd_data;
      next_oe     = ~mem_rd_data[7];
      next_bitcnt = 4'h0;
      next_addr   = (addr + 11'h001) & addr_mask;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state     <= EEP_IDLE;
      shreg     <= 8'h00;
      bitcnt    <= 4'h0;
      addr      <= '0;
      oe        <= 1'b0;
      have_data <= 1'b0;
      wp_seen   <= 1'b0;
      timer     <= '0;
      mem_wr    <= '0;
    end else begin
      state     <= next_state;
      shreg     <= next_shreg;
      bitcnt    <= next_bitcnt;
      addr      <= next_addr;
      oe        <= next_oe;
      have_data <= next_have_data;
      wp_seen   <= next_wp_seen;
      timer     <= next_timer;
      mem_wr    <= next_wr;
    end
  end

  assign sda_out     = 1'b0;
  assign sda_oe      = oe;
  assign mem_rd_addr = addr;
  assign write_busy  = (state == EEP_BUSY);

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence s_sel_ok;
    scl_fall && !start_det && !stop_det && state == EEP_SEL
      && bitcnt == 4'h8 && sel_match;
  endsequence
  sequence s_sel_bad;
    scl_fall && !start_det && !stop_det && state == EEP_SEL
      && bitcnt == 4'h8 && !sel_match;
  endsequence

  AST_SEL_ACK: assert property (s_sel_ok |=> sda_oe)
    else $error("matching select not acknowledged");
  AST_SEL_NACK: assert property (s_sel_bad |=>
    state == EEP_IDLE && !sda_oe)
    else $error("mismatching select answered");
  AST_BUSY_QUIET: assert property (write_busy |-> !sda_oe)
    else $error("data line driven while busy");
  AST_START: assert property (start_det && !write_busy |=>
    state == EEP_SEL && bitcnt == 4'h0)
    else $error("start not taken");
  AST_LAUNCH: assert property (stop_det && launch_ok
    && !write_busy |=> write_busy)
    else $error("write cycle not launched");
  AST_NO_LAUNCH: assert property (stop_det && !launch_ok
    && !write_busy |=> state == EEP_IDLE)
    else $error("stop did not end the transfer");
  AST_WP_NACK: assert property (state == EEP_WACK && wp_seen
    |-> !sda_oe && !have_data)
    else $error("protected data byte acknowledged");
  AST_PAGE_WRAP: assert property (latch_en |=>
    addr[10:4] == $past(addr[10:4]))
    else $error("write address left its page");
  AST_READ_INC: assert property (rd_load |=>
    addr == (($past(addr) + 11'h001) & addr_mask))
    else $error("read counter not advanced");
  AST_READ_NACK: assert property (state == EEP_RACK && scl_rise
    && sda_s && !start_det && !stop_det |=> state == EEP_IDLE)
    else $error("read not ended on master no-ack");
  AST_BUSY_HOLD: assert property ($rose(write_busy) |->
    write_busy [*8])
    else $error("write cycle ended too early");

endmodule

// ==== sim/eep_bus_master.sv ====
// Purpose: Behavioural two-wire bus master for the memory slave
// Assumes: Data line has a pull-up, the slave only pulls it low
// Notes:   Bit period is 40 system clocks, 160 ns
`timescale 1ns/100ps

module eep_bus_master (
  // Clock
  input  wire logic clk_sys,
  // Bus lines
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_rel
);
  // ****************************************
  // Idle bus
  // ****************************************
  // Clock stands high between frames, data released
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end

  // ****************************************
  // Bus phases
  // ****************************************
  task automatic q();
    repeat (10) @(posedge clk_sys);
  endtask

  task automatic start_cond();
    sda_rel <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_rel <= 1'b0;
    q();
    scl <= 1'b0;
    q();
  endtask

  task automatic stop_cond();
    sda_rel <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda_rel <= 1'b1;
    q();
  endtask

  // Data changes a quarter period after clock low
  task automatic bit_io(input logic b, output logic r);
    sda_rel <= b;
    q();
    scl <= 1'b1;
    q();
    r = sda_line;
    q();
    scl <= 1'b0;
    q();
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  task automatic recv_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~ack, r);
  endtask
endmodule

// ==== sim/eep_slave_bench.sv ====
// Purpose: Self-checking bench of the two-wire memory slave
// Assumes: 512 byte density, select b1 is address bit 8, 256 byte last
// Notes:   Short write cycle so busy polling stays quick
`timescale 1ns/100ps

module eep_slave_bench
  import eep_pkg::*;
;
  // ****************************************
  // Signals and array model
  // ****************************************
  localparam int WCYC = 800;
  logic        clk_sys = 1'b0;
  logic        srst;
  logic        wp;
  logic [1:0]  ubits;
  logic        sda_drv;
  logic        scl;
  logic        sda_rel;
  logic        sda_oe;
  logic        write_busy;
  logic [10:0] mem_rd_addr;
  eep_wr_type  mem_wr;
  logic [7:0]  mem [0:2047];
  wire  logic  sda_line = sda_rel & (~sda_oe | sda_drv);
  int          n_fail = 0;
  int          checked = 0;
  int          busy_cnt = 0;

  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (write_busy) busy_cnt <= busy_cnt + 1;
  always @(posedge clk_sys) if (mem_wr.en) mem[mem_wr.addr] <= mem_wr.data;

  eep_slave #(.WRITE_CYCLE_CYC(WCYC)) eep_slave_inst (
    .clk_sys(clk_sys), .srst(srst), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_drv), .sda_oe(sda_oe), .chip_select_pin_0(1'b1),
    .chip_select_pin_1(1'b0), .chip_select_pin_2(1'b1),
    .write_protect_input(wp), .upper_bits_used(ubits),
    .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem[mem_rd_addr]),
    .mem_wr(mem_wr), .write_busy(write_busy));

  eep_bus_master eep_bus_master_inst (
    .clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_rel(sda_rel));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] pat(input logic [10:0] a);
    return a[7:0] ^ {a[10:8], 5'h0a};
  endfunction

  task automatic check(input string nm, input logic [10:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic sel(input logic [7:0] s, input logic exp);
    logic k;
    eep_bus_master_inst.start_cond();
    eep_bus_master_inst.send_byte(s, k);
    check("select ack", k, exp);
  endtask

  task automatic set_addr(input logic [7:0] s, adr);
    logic k;
    sel(s, 1'b1);
    eep_bus_master_inst.send_byte(adr, k);
    check("address ack", k, 1'b1);
  endtask

  task automatic page_wr(input logic [7:0] s, adr, d [$], input logic da);
    logic k;
    set_addr(s, adr);
    foreach (d[i]) begin
      eep_bus_master_inst.send_byte(d[i], k);
      check("data ack", k, da);
    end
    eep_bus_master_inst.stop_cond();
  endtask

  // Master acks all bytes but the last
  task automatic rd(input logic [7:0] s, e [$]);
    logic [7:0] v;
    sel(s, 1'b1);
    foreach (e[i]) begin
      eep_bus_master_inst.recv_byte(i < e.size() - 1, v);
      check("read data", v, e[i]);
    end
    eep_bus_master_inst.stop_cond();
  endtask

  // ****************************************
  // Watchdog
  // ****************************************
  initial begin
    repeat (100000) @(posedge clk_sys);
    n_fail++;
    results();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    logic k;
    for (int i = 0; i < 2048; i++) mem[i] = pat(i[10:0]);
    srst <= 1'b1;
    wp <= 1'b0;
    ubits <= 2'h1;
    repeat (12) @(negedge clk_sys);
    check("oe in reset", sda_oe, 1'b0);
    check("busy in reset", write_busy, 1'b0);
    check("addr in reset", mem_rd_addr, 11'h000);
    check("wr in reset", mem_wr.en, 1'b0);
    @(posedge clk_sys);
    srst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    // Byte with no start must be ignored
    eep_bus_master_inst.send_byte(8'h5a, k);
    check("no start ack", k, 1'b0);
    sel(8'h2a, 1'b0);
    sel(8'h52, 1'b0);
    sel(8'h5e, 1'b0);
    eep_bus_master_inst.stop_cond();
    // Page write from slot e wraps into slot 0
    page_wr(8'h5a, 8'h0e, '{8'h11, 8'h22, 8'h33}, 1'b1);
    repeat (4) @(negedge clk_sys);
    check("busy after stop", write_busy, 1'b1);
    sel(8'h5a, 1'b0);
    for (int t = 0; t < 20 && k !== 1'b1; t++) begin
      eep_bus_master_inst.start_cond();
      eep_bus_master_inst.send_byte(8'h5a, k);
    end
    eep_bus_master_inst.stop_cond();
    check("poll ack", k, 1'b1);
    check("busy length", busy_cnt, WCYC);
    repeat (8) @(negedge clk_sys);
    check("no data no cycle", write_busy, 1'b0);
    check("slot e", mem[11'h10e], 8'h11);
    check("slot f", mem[11'h10f], 8'h22);
    check("slot 0", mem[11'h100], 8'h33);
    check("next page", mem[11'h110], pat(11'h110));
    // Protected write, then reads with protect still high
    @(posedge clk_sys);
    wp <= 1'b1;
    page_wr(8'h5a, 8'h05, '{8'h77}, 1'b0);
    repeat (8) @(negedge clk_sys);
    check("wp no cycle", write_busy, 1'b0);
    check("wp location", mem[11'h105], pat(11'h105));
    set_addr(8'h5a, 8'hff);
    rd(8'h5b, '{pat(11'h1ff), pat(11'h000)});
    rd(8'h59, '{pat(11'h001)});
    set_addr(8'h5a, 8'h0e);
    rd(8'h5b, '{8'h11, 8'h22, pat(11'h110)});
    // Smallest density: b1 is a chip select, counter wraps at 256
    @(posedge clk_sys);
    ubits <= 2'h0;
    set_addr(8'h5a, 8'hff);
    rd(8'h5b, '{pat(11'h0ff), pat(11'h000)});
    sel(8'h58, 1'b0);
    eep_bus_master_inst.stop_cond();
    repeat (8) @(negedge clk_sys);
    check("oe idle", sda_oe, 1'b0);
    results();
  end
endmodule
